// ### common/tcpm_map.vh
// register map, field positions, mode codes and control reset value of the timer channel
`ifndef TCPM_MAP_VH
`define TCPM_MAP_VH

// ==========================================================
// register byte offsets
`define TCPM_OFS_A 8'h00
`define TCPM_OFS_B 8'h04
`define TCPM_OFS_CNT 8'h08
`define TCPM_OFS_CTRL 8'h0C
`define TCPM_OFS_STAT 8'h10

// ==========================================================
// channel_control_reg fields
`define TCPM_CTRL_FUNC_LSB 0
`define TCPM_CTRL_FUNC_MSB 3
`define TCPM_CTRL_MODE4 4
`define TCPM_CTRL_MODE5 5
`define TCPM_CTRL_MODE6 6
`define TCPM_CTRL_EDPOLB 7
`define TCPM_CTRL_EDBOTH 8
`define TCPM_CTRL_PRE_LSB 9
`define TCPM_CTRL_PRE_MSB 10
`define TCPM_CTRL_BUS_LSB 11
`define TCPM_CTRL_BUS_MSB 12
`define TCPM_CTRL_FRC_A 13
`define TCPM_CTRL_FRC_B 14
`define TCPM_CTRL_STORED_MSB 12
`define TCPM_CTRL_RST 13'h0000

// ==========================================================
// status register fields
`define TCPM_STAT_FLAG 0
`define TCPM_STAT_OUT 1
`define TCPM_STAT_IN 2

// ==========================================================
// function codes in the low mode bits
`define TCPM_FN_IDLE 4'h0
`define TCPM_FN_PEC 4'h1
`define TCPM_FN_QUADRATURE_DECODE_MODE 4'h2
`define TCPM_FN_WINDOWED_TIME_ACCUM_MODE 4'h3
`define TCPM_FN_MC 4'h4
`define TCPM_FN_PWFM 4'h5

`endif

// ### core/tcpm_channel.v
// one timer channel: edge count, quadrature, time accumulation, modulus count, pwm
`timescale 1ns/1ps
`include "tcpm_map.vh"

// Notes on behaviour
// - mode bit 6 picks continuous or single-shot
// - match A clears counter, starts edge counting
// - match B stops counting, sets flag
// - continuous: next A match restarts counting
// - single-shot: A ignored until A rewritten
// - forces ignored in counting and modulus modes
// - quadrature uses neighbour channel's filtered input
// - quadrature: internal counter, flag on A1 equal
// - bit 6 clear: direction here, count neighbour
// - bit 6 set: phase A here, B neighbour
// - prescaler sets accumulation increment rate
// - accumulate while input equals polarity bit
// - modulus clock internal or input edge
// - up mode: A1 match flags, clears counter
// - up/down: turn at A1, B1 zero
// - A writes take effect at once
// - pwm: B2 to B1 now or at A1
// - pwm: A sets polarity, B complement, clear
// - pwm flag on B, or both with bit 5
// - forces act like matches without flag
// - A equals B gives 100%, A zero 0%
module tcpm_channel #(
  parameter CW = 24
) (
  // clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // time base and neighbour channel
  input wire [CW-1:0] cbus_i,
  input wire nbr_filt_i,
  input wire nbr_edge_polarity_i,
  // pin side
  input wire in_pin_i,
  output reg filt_o,
  output reg edge_polarity_o,
  output reg out_o,
  output reg flag_o
);

  // ==========================================================
  // state
  reg [CW-1:0] a1_q;
  reg [CW-1:0] b1_q;
  reg [CW-1:0] b2_q;
  reg [CW-1:0] cnt_q;
  reg [`TCPM_CTRL_STORED_MSB:0] ctrl_q;
  reg en_q;
  reg armed_q;
  reg down_q;
  reg ma_prev_q;
  reg mb_prev_q;
  reg [1:0] pre_cnt_q;
  reg sync1_q;
  reg sync2_q;
  reg filt_prev_q;
  reg nbr_prev_q;

  // ==========================================================
  // control fields
  wire [3:0] func = ctrl_q[`TCPM_CTRL_FUNC_MSB:`TCPM_CTRL_FUNC_LSB];
  wire mode4 = ctrl_q[`TCPM_CTRL_MODE4];
  wire mode5 = ctrl_q[`TCPM_CTRL_MODE5];
  wire mode6 = ctrl_q[`TCPM_CTRL_MODE6];
  wire edge_polarity_bit = ctrl_q[`TCPM_CTRL_EDPOLB];
  wire edge_both_select = ctrl_q[`TCPM_CTRL_EDBOTH];
  wire [1:0] channel_prescaler = ctrl_q[`TCPM_CTRL_PRE_MSB:`TCPM_CTRL_PRE_LSB];
  wire [1:0] bus_select = ctrl_q[`TCPM_CTRL_BUS_MSB:`TCPM_CTRL_BUS_LSB];

  wire is_pec = (func == `TCPM_FN_PEC);
  wire is_quadrature_decode_mode = (func == `TCPM_FN_QUADRATURE_DECODE_MODE);
  wire is_windowed_time_accum_mode = (func == `TCPM_FN_WINDOWED_TIME_ACCUM_MODE);
  wire is_mc = (func == `TCPM_FN_MC);
  wire is_pwfm = (func == `TCPM_FN_PWFM);

  // ==========================================================
  // wishbone decode; an access is served on the edge that raises ack
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire wr_a = wr & (wb_adr_i == `TCPM_OFS_A);
  wire wr_b = wr & (wb_adr_i == `TCPM_OFS_B);
  wire wr_cnt = wr & (wb_adr_i == `TCPM_OFS_CNT);
  wire wr_ctrl = wr & (wb_adr_i == `TCPM_OFS_CTRL);
  wire wr_stat = wr & (wb_adr_i == `TCPM_OFS_STAT);
  // forces are one-shot write bits, never stored
  wire frc_a = wr_ctrl & wb_dat_i[`TCPM_CTRL_FRC_A];
  wire frc_b = wr_ctrl & wb_dat_i[`TCPM_CTRL_FRC_B];

  // ==========================================================
  // input edges on the filtered pin and on the neighbour's filter
  wire rise = filt_o & ~filt_prev_q;
  wire fall = ~filt_o & filt_prev_q;
  wire qual_edge = edge_both_select ? (rise | fall) : (edge_polarity_bit ? rise : fall);
  wire nbr_rise = nbr_filt_i & ~nbr_prev_q;
  wire nbr_fall = ~nbr_filt_i & nbr_prev_q;

  // prescaled internal tick, divide by prescaler+1
  wire pre_tick = (pre_cnt_q == channel_prescaler);

  // ==========================================================
  // time base and comparators; bus_select zero takes the own counter
  wire [CW-1:0] tb = (bus_select == 2'b00) ? cnt_q : cbus_i;
  wire match_a = (tb == a1_q);
  wire match_b = (tb == b1_q);
  // window modes act once per match, not on every cycle it persists
  wire ma_new = match_a & ~ma_prev_q;
  wire mb_new = match_b & ~mb_prev_q;

  // ==========================================================
  // quadrature step and direction
  reg q_step;
  reg q_up;
  always @* begin
    q_step = 1'b0;
    q_up = 1'b0;
    if (!mode6) begin
      // count from neighbour, direction from own pin
      q_step = nbr_edge_polarity_i ? nbr_rise : nbr_fall;
      q_up = (filt_o == edge_polarity_bit);
    end else begin
      // phase A here, phase B on neighbour, every transition counts
      q_step = (filt_o ^ filt_prev_q) | (nbr_filt_i ^ nbr_prev_q);
      q_up = (filt_o ^ nbr_prev_q) ^ edge_polarity_bit;
    end
  end
  wire [CW-1:0] q_next = q_up ? cnt_q + 1'b1 : cnt_q - 1'b1;

  // pwm match on the own counter; zero in A never matches so output stays inactive
  wire pa = is_pwfm & (cnt_q == a1_q) & (a1_q != {CW{1'b0}});
  wire pb = is_pwfm & (cnt_q == b1_q);

  // ==========================================================
  // two flops on the pin, then the filter stage shared with the next channel
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      filt_o <= 1'b0;
      filt_prev_q <= 1'b0;
      nbr_prev_q <= 1'b0;
    end else begin
      sync1_q <= in_pin_i;
      sync2_q <= sync1_q;
      filt_o <= sync2_q;
      filt_prev_q <= filt_o;
      nbr_prev_q <= nbr_filt_i;
    end
  end

  // ==========================================================
  // bus answer: one wait state, unmapped reads give zero
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        if (wb_adr_i == `TCPM_OFS_A) begin
          wb_dat_o[CW-1:0] <= a1_q;
        end else if (wb_adr_i == `TCPM_OFS_B) begin
          wb_dat_o[CW-1:0] <= b1_q;
        end else if (wb_adr_i == `TCPM_OFS_CNT) begin
          wb_dat_o[CW-1:0] <= cnt_q;
        end else if (wb_adr_i == `TCPM_OFS_CTRL) begin
          wb_dat_o[`TCPM_CTRL_STORED_MSB:0] <= ctrl_q;
        end else if (wb_adr_i == `TCPM_OFS_STAT) begin
          wb_dat_o[`TCPM_STAT_FLAG] <= flag_o;
          wb_dat_o[`TCPM_STAT_OUT] <= out_o;
          wb_dat_o[`TCPM_STAT_IN] <= filt_o;
        end
      end
    end
  end

  // ==========================================================
  // control register and prescaler
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= `TCPM_CTRL_RST;
      edge_polarity_o <= 1'b0;
      pre_cnt_q <= 2'b00;
    end else begin
      if (wr_ctrl && wb_sel_i[0]) begin
        ctrl_q[7:0] <= wb_dat_i[7:0];
        edge_polarity_o <= wb_dat_i[`TCPM_CTRL_EDPOLB];
      end
      if (wr_ctrl && wb_sel_i[1]) begin
        ctrl_q[`TCPM_CTRL_STORED_MSB:8] <= wb_dat_i[`TCPM_CTRL_STORED_MSB:8];
      end
      // prescaler only paces internal increments
      if (pre_tick) begin
        pre_cnt_q <= 2'b00;
      end else begin
        pre_cnt_q <= pre_cnt_q + 2'b01;
      end
    end
  end

  // ==========================================================
  // channel engine: comparators, counter, flag and output flip-flop
  // later assignments win, so flag sets override a same-cycle clear
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      a1_q <= {CW{1'b0}};
      b1_q <= {CW{1'b0}};
      b2_q <= {CW{1'b0}};
      cnt_q <= {CW{1'b0}};
      en_q <= 1'b0;
      armed_q <= 1'b0;
      down_q <= 1'b0;
      ma_prev_q <= 1'b0;
      mb_prev_q <= 1'b0;
      out_o <= 1'b0;
      flag_o <= 1'b0;
    end else begin
      ma_prev_q <= match_a;
      mb_prev_q <= match_b;

      // software clear of the sticky flag
      if (wr_stat && wb_sel_i[0] && wb_dat_i[`TCPM_STAT_FLAG]) begin
        flag_o <= 1'b0;
      end

      // register A always lands in A1 at once
      if (wr_a) begin
        a1_q <= wb_dat_i[CW-1:0];
        armed_q <= 1'b1;
      end
      // register B lands in B2 and B1 outside modulus mode, which holds B1 at zero; pwm with bit 6 leaves B1 to the A1 match
      if (wr_b && !is_mc) begin
        b2_q <= wb_dat_i[CW-1:0];
        if (!(is_pwfm && mode6)) begin
          b1_q <= wb_dat_i[CW-1:0];
        end
      end
      if (is_mc) begin
        b1_q <= {CW{1'b0}};
      end

      // windowed edge counting and time accumulation
      if (is_pec || is_windowed_time_accum_mode) begin
        if (ma_new && (armed_q || !mode6)) begin
          cnt_q <= {CW{1'b0}};
          en_q <= 1'b1;
          if (mode6) begin
            armed_q <= 1'b0;
          end
        end else if (mb_new && en_q) begin
          en_q <= 1'b0;
          flag_o <= 1'b1;
        end else if (en_q) begin
          if (is_pec && qual_edge) begin
            cnt_q <= cnt_q + 1'b1;
          end
          if (is_windowed_time_accum_mode && pre_tick && (filt_o == edge_polarity_bit)) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end

      // quadrature decode keeps the counter it finds on entry
      if (is_quadrature_decode_mode && q_step) begin
        cnt_q <= q_next;
        if (q_next == a1_q) begin
          flag_o <= 1'b1;
        end
      end

      // modulus counter
      if (is_mc && (mode6 ? qual_edge : pre_tick)) begin
        if (!mode4) begin
          if (cnt_q == a1_q) begin
            cnt_q <= {CW{1'b0}};
            flag_o <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end else if (!down_q) begin
          if (cnt_q == a1_q) begin
            down_q <= 1'b1;
            flag_o <= 1'b1;
            cnt_q <= cnt_q - 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end else begin
          if (cnt_q == b1_q) begin
            down_q <= 1'b0;
            cnt_q <= cnt_q + 1'b1;
            if (mode5) begin
              flag_o <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      end
      if (!is_mc || !mode4) begin
        down_q <= 1'b0;
      end

      // pwm with programmable period on the own counter, bus select ignored
      if (is_pwfm && pre_tick) begin
        if (pb) begin
          cnt_q <= {CW{1'b0}};
          out_o <= ~edge_polarity_bit;
          flag_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        // A is applied after B so a shared value leaves the output active
        if (pa) begin
          out_o <= edge_polarity_bit;
          if (mode5) begin
            flag_o <= 1'b1;
          end
        end
        if ((cnt_q == a1_q) && mode6) begin
          b1_q <= b2_q;
        end
      end

      // forces act only in pwm mode and never touch the flag
      if (is_pwfm && frc_b) begin
        out_o <= ~edge_polarity_bit;
        cnt_q <= {CW{1'b0}};
      end
      if (is_pwfm && frc_a) begin
        out_o <= edge_polarity_bit;
      end

      // software load of the counter has the last word
      if (wr_cnt) begin
        cnt_q <= wb_dat_i[CW-1:0];
      end
    end
  end

endmodule // tcpm_channel

// ### verification/tcpm_channel_assertions.sv
// port checker for the timer channel
`timescale 1ns/1ps
module tcpm_channel_chk (
  // clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // pins
  input wire in_pin_i,
  input wire filt_o,
  input wire out_o,
  input wire flag_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [2:0] up_q;
  // ==========
  // cycles since reset, so the input pipe is full before it is judged
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  end
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_CNT_TOP: assert property (wb_ack_o && !wb_we_i && wb_adr_i <= 8'h08 |-> wb_dat_o[31:24] == 8'h00)
    else $error("counter read upper bits set");
  AST_UNMAP: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_STAT_RD: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10
    |-> wb_dat_o[2:0] == {$past(filt_o), $past(out_o), $past(flag_o)})
    else $error("status read disagrees with pins");
  AST_FLAG_HOLD: assert property ($fell(flag_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
    && wb_adr_i == 8'h10 && wb_sel_i[0] && wb_dat_i[0]))
    else $error("flag cleared without software");
  AST_FILT_DLY: assert property (up_q == 3'h4 |-> filt_o == $past(in_pin_i, 3))
    else $error("filtered input not three cycles behind pin");
endmodule // tcpm_channel_chk
bind tcpm_channel tcpm_channel_chk u_chk (.core_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .in_pin_i, .filt_o, .out_o, .flag_o);

// ### verification/tcpm_channel_tb.sv
// self-checking bench for the timer channel
`timescale 1ns/1ps
`include "tcpm_map.vh"
module tcpm_channel_tb;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic en = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] r;
  logic [23:0] tb_q = 24'h0;
  logic ack, filt, epol, out, flag, pha, phb;
  int bad_count = 0;
  int checks_done = 0;
  int i, n;
  int av[3] = '{3, 9, 0};
  int ex[3] = '{40, 0, 100};
  always #25 core_clk_i = ~core_clk_i;
  // shared time base wraps every 128 cycles so windows repeat
  always @(posedge core_clk_i) tb_q <= en ? ((tb_q + 24'h1) & 24'h7F) : 24'h0;
  tcpm_channel dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cbus_i(tb_q),
    .nbr_filt_i(phb), .nbr_edge_polarity_i(1'b1), .in_pin_i(pha), .filt_o(filt), .edge_polarity_o(epol),
    .out_o(out), .flag_o(flag));
  tcpm_pin_model pm (.clk_i(core_clk_i), .en_i(en), .pha_o(pha), .phb_o(phb));
  // ==========
  // report, compare and bus tasks
  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // single classic cycle; holds everything until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    r = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    if (k >= 20) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wflag();
    int k;
    k = 0;
    while (flag !== 1'b1 && k < 400) begin
      @(posedge core_clk_i);
      k++;
    end
    if (k >= 400) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(`TCPM_OFS_CTRL); chk(r, 32'h0);
    wr(8'h14, 32'h5); rd(8'h14); chk(r, 32'h0);
    // pwm active high, low time counted: duty, 100% and 0% active over ten periods
    wr(`TCPM_OFS_CTRL, 32'h85); wr(`TCPM_OFS_B, 32'h9);
    for (i = 0; i < 3; i++) begin
      wr(`TCPM_OFS_A, av[i]);
      repeat (20) @(posedge core_clk_i);
      n = 0;
      repeat (100) begin
        @(posedge core_clk_i);
        if (out === 1'b0) n++;
      end
      chk(n, ex[i]);
    end
    // flag on A match only with mode bit 5
    for (i = 0; i < 2; i++) begin
      wr(`TCPM_OFS_CTRL, i ? 32'hA5 : 32'h85); wr(`TCPM_OFS_A, 32'h14); wr(`TCPM_OFS_B, 32'hC8);
      wr(`TCPM_OFS_CNT, 32'h0); wr(`TCPM_OFS_STAT, 32'h1);
      repeat (30) @(posedge core_clk_i);
      rd(`TCPM_OFS_STAT); chk(r[1:0], {1'b1, i[0]});
    end
    // forces move the output, not the flag
    wr(`TCPM_OFS_CTRL, 32'h85); wr(`TCPM_OFS_STAT, 32'h1); wr(`TCPM_OFS_CTRL, 32'h4085);
    rd(`TCPM_OFS_CNT); chk(32'(r < 32'h8), 32'h1);
    rd(`TCPM_OFS_STAT); chk(r[1:0], 2'h0);
    wr(`TCPM_OFS_CTRL, 32'h2085); rd(`TCPM_OFS_STAT); chk(r[1:0], 2'h2);
    // modulus up count stays within A
    wr(`TCPM_OFS_CTRL, 32'h04); wr(`TCPM_OFS_A, 32'h5); wr(`TCPM_OFS_CNT, 32'h0); wr(`TCPM_OFS_STAT, 32'h1);
    rd(`TCPM_OFS_CNT); chk(32'(r <= 32'h5), 32'h1);
    rd(`TCPM_OFS_STAT); chk(r[0], 1'b1);
    // edge counting in window 39..103, rising then both edges
    en <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(`TCPM_OFS_CTRL, i ? 32'h981 : 32'h881); wr(`TCPM_OFS_B, 32'h67); wr(`TCPM_OFS_A, 32'h27);
      wflag(); wr(`TCPM_OFS_STAT, 32'h1); wflag();
      rd(`TCPM_OFS_CNT); chk(r, i ? 32'h8 : 32'h4);
    end
    // the output still holds the level left by the last pwm force; force a in the same write would win over a working force b
    wr(`TCPM_OFS_STAT, 32'h1); wr(`TCPM_OFS_CTRL, 32'h6981); rd(`TCPM_OFS_STAT); chk(r[1:0], 2'h2);
    // single shot: one window per write of A
    wr(`TCPM_OFS_CTRL, 32'h8C1); wr(`TCPM_OFS_A, 32'h27); wflag();
    rd(`TCPM_OFS_CNT); chk(r, 32'h4);
    wr(`TCPM_OFS_STAT, 32'h1);
    repeat (200) @(posedge core_clk_i);
    rd(`TCPM_OFS_STAT); chk(r[0], 1'b0);
    // high time at prescale 1 and 4
    for (i = 0; i < 2; i++) begin
      wr(`TCPM_OFS_CTRL, i ? 32'hE83 : 32'h883); wr(`TCPM_OFS_B, 32'h67); wr(`TCPM_OFS_A, 32'h27);
      wflag(); wr(`TCPM_OFS_STAT, 32'h1); wflag(); rd(`TCPM_OFS_CNT);
      chk(32'(i ? (r >= 32'h7 && r <= 32'h9) : (r >= 32'h1F && r <= 32'h21)), 32'h1);
    end
    // quadrature: 16 phase steps, sign set by polarity
    en <= 1'b0;
    wr(`TCPM_OFS_A, 32'h6C);
    for (i = 0; i < 2; i++) begin
      wr(`TCPM_OFS_CNT, 32'h64); wr(`TCPM_OFS_CTRL, i ? 32'hC2 : 32'h42);
      rd(`TCPM_OFS_CNT); chk(r, 32'h64);
      chk(epol, i[0]);
      wr(`TCPM_OFS_STAT, 32'h1);
      en <= 1'b1;
      repeat (64) @(posedge core_clk_i);
      en <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      rd(`TCPM_OFS_CNT);
      // phase b leads in the model, so polarity clear counts down and set counts up
      chk(r, i ? 32'h74 : 32'h54);
      chk(flag, r == 32'h74);
    end
    end_sim();
  end
endmodule // tcpm_channel_tb

// ### verification/tcpm_pin_model.sv
// model of the encoder and pulse source at the channel pins
`timescale 1ns/1ps
module tcpm_pin_model (
  // clock and run control
  input wire logic clk_i,
  input wire logic en_i,
  // phase outputs
  output logic pha_o,
  output logic phb_o
);
  logic [1:0] step_q = 2'h0;
  logic [1:0] ph_q = 2'h0;
  // one gray step every 4 cycles; phases hold while stopped so no stray edges
  always @(posedge clk_i) begin
    step_q <= en_i ? step_q + 2'h1 : 2'h0;
    if (en_i && step_q == 2'h3) begin
      ph_q <= ph_q + 2'h1;
    end
  end
  // phase b leads phase a by a quarter period; b feeds the neighbour input
  assign pha_o = ph_q[1];
  assign phb_o = ph_q[1] ^ ph_q[0];
endmodule // tcpm_pin_model
